//--- ebu_external_bus_unit.sv
// External bus unit: bus cycles, windows, chip selects and hold arbitration
`timescale 1ns/1ps

// Notes on behaviour
// R1: Single chip or four 8/16 mux/demux modes
// R2: Demux: address port, data full or low
// R3: Mux: address then data on shared port
// R4: Cycle, tristate, ALE and delay programmable
// R5: Four windows, each select plus config pair
// R6: Overlap: window four over three, two over one
// R7: Unmatched addresses use default configuration
// R8: Five chip selects: four windows plus default
// R9: Per-window ready polarity bit
// R10: Ready-enabled cycles wait for active ready
// R11: Arbitration only when hold enable set
// R12: Enabled arbitration drives request, ack, hold pins; code drives ack only as master, hold is an input only
// R13: Reset: master, acknowledge pin is output
// R14: Direction bit one: slave, ack is input
// R15: Segment lines 8, 4, 2 or none
// R16: Default: chip selects lag ALE rise
// R17: Timing bit set: selects change with ALE
// R18: Window match compares start and size
// R19: Master finishes cycle, floats, then acknowledges
module ebu_external_bus_unit (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // CPU side request
    input  wire logic             reqValid,
    input  wire logic             reqWrite,
    input  wire logic [23:0]      reqAddr,
    input  wire logic [15:0]      reqWdata,
    output logic                  reqReady,
    output logic                  respValid,
    output logic                  respErr,
    output logic      [15:0]      respRdata,
    // Configuration
    input  wire logic             singleChip,
    input  wire logic             holdEnableBit,
    input  wire logic             chipSelectTimingBit,
    input  wire logic             ackPinDirectionBit,
    input  wire logic [1:0]       addrSpace,
    input  wire logic [15:0]      defaultBusConfig,
    input  wire logic [3:0][15:0] windowBusConfig,
    input  wire logic [3:0][15:0] windowAddressSelect,
    // Bus pins
    output logic      [15:0]      addressPortOut,
    output logic      [7:0]       segAddrOut,
    output logic      [7:0]       segAddrOe,
    input  wire logic [15:0]      sharedDataPortIn,
    output logic      [15:0]      sharedDataPortOut,
    output logic                  dataPortLowOe,
    output logic                  dataPortHighOe,
    output logic                  aleOut,
    output logic                  rdNOut,
    output logic                  wrNOut,
    output logic      [4:0]       chipSelectNOut,
    output logic                  busOwnOe,
    input  wire logic             readyIn,
    // Arbitration pins
    input  wire logic             holdNIn,
    output logic                  busRequestNOut,
    output logic                  busRequestOe,
    input  wire logic             holdAckNIn,
    output logic                  holdAckNOut,
    output logic                  holdAckOe,
    output logic                  busBusy
);
    typedef struct packed {
        ebu_pkg::ebu_state_t st;
        logic [4:0]  cnt;
        logic [15:0] cfg;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        ale;
        logic        rdN;
        logic        wrN;
        logic [4:0]  csN;
        logic [4:0]  csNext;
        logic        csPend;
        logic [15:0] dataOut;
        logic        oeLo;
        logic        oeHi;
        logic [15:0] rdata;
        logic        respValid;
        logic        respErr;
        logic        own;
        logic        holdAckN;
        logic        busReqN;
    } ebu_regs_t;

    ebu_regs_t q;
    ebu_regs_t n;

    logic [2:0]  winSel;
    logic [15:0] selCfg;
    logic [4:0]  selCs;
    logic        slaveMode;
    logic        holdWanted;
    logic        canStart;
    logic        muxMode;
    logic        wideMode;
    logic        readyActive;
    logic [7:0]  segMask;

    ebu_window_decode uDecode (
        .addr       (reqAddr),
        .winAddrSel (windowAddressSelect),
        .winSel     (winSel)
    );

    assign slaveMode = holdEnableBit && ackPinDirectionBit; // R14
    assign holdWanted = holdEnableBit && !ackPinDirectionBit && !holdNIn; // R11
    assign muxMode = q.cfg[ebu_pkg::BC_MODE_LSB];
    assign wideMode = q.cfg[ebu_pkg::BC_MODE_LSB + 1];
    assign readyActive = (readyIn == q.cfg[ebu_pkg::BC_READY_POLARITY_BIT]); // R9
    assign canStart = singleChip || q.own;

    always_comb begin
        selCfg = defaultBusConfig; // R7
        selCs  = 5'h01;
        if (winSel != ebu_pkg::SEL_DEFAULT) begin
            selCfg = windowBusConfig[winSel - 3'h1]; // R5
            selCs  = 5'h01 << winSel; // R8
        end
    end

    always_comb begin
        unique case (addrSpace)
            ebu_pkg::SPACE_64K:  segMask = ebu_pkg::SEG_MASK_64K; // R15
            ebu_pkg::SPACE_256K: segMask = ebu_pkg::SEG_MASK_256K;
            ebu_pkg::SPACE_1M:   segMask = ebu_pkg::SEG_MASK_1M;
            ebu_pkg::SPACE_16M:  segMask = ebu_pkg::SEG_MASK_16M;
        endcase
    end

    assign reqReady = (q.st == ebu_pkg::S_IDLE) && !holdWanted && canStart;

    always_comb begin
        n = q;
        n.respValid = 1'b0;
        unique case (q.st)
            ebu_pkg::S_IDLE: begin
                if (holdWanted) begin
                    // Bus already idle: release it, acknowledge next cycle
                    n.own = 1'b0; // R19
                    n.st  = ebu_pkg::S_HOLD;
                end else if (slaveMode) begin
                    // Slave takes the bus once acknowledged and keeps it until reqValid drops
                    if (!q.own) begin
                        n.busReqN = !reqValid; // R12
                        n.own     = !holdAckNIn && !q.busReqN;
                    end else if (!reqValid) begin
                        n.busReqN = 1'b1;
                        n.own     = 1'b0;
                    end
                end else begin
                    n.own     = 1'b1; // R13
                    n.busReqN = 1'b1;
                end
                if (reqReady && reqValid) begin
                    n.addr  = reqAddr;
                    n.wdata = reqWdata;
                    n.write = reqWrite;
                    n.cfg   = selCfg;
                    if (singleChip) begin
                        n.respValid = 1'b1; // R1
                        n.respErr   = 1'b1;
                        n.rdata     = 16'h0000;
                    end else begin
                        n.respErr = 1'b0;
                        n.st      = ebu_pkg::S_ADDR;
                        n.ale     = 1'b1;
                        n.cnt     = {4'h0, selCfg[ebu_pkg::BC_ALELONG]}; // R4
                        n.dataOut = reqAddr[15:0]; // R3
                        n.oeLo    = selCfg[ebu_pkg::BC_MODE_LSB];
                        n.oeHi    = selCfg[ebu_pkg::BC_MODE_LSB];
                        n.csNext  = selCfg[ebu_pkg::BC_CSEN] ? ~selCs : ebu_pkg::CS_IDLE;
                        if (chipSelectTimingBit) begin
                            n.csN    = selCfg[ebu_pkg::BC_CSEN] ? ~selCs
                                                                : ebu_pkg::CS_IDLE; // R17
                            n.csPend = 1'b0;
                        end else begin
                            n.csPend = 1'b1; // R16
                        end
                    end
                end
            end
            ebu_pkg::S_ADDR: begin
                if (q.csPend) begin
                    n.csN    = q.csNext; // R16
                    n.csPend = 1'b0;
                end
                if (q.cnt != 5'h00) begin
                    n.cnt = q.cnt - 5'h01;
                end else begin
                    n.ale     = 1'b0;
                    n.dataOut = q.wdata; // R2
                    n.oeLo    = q.write;
                    n.oeHi    = q.write && wideMode; // R2
                    n.cnt     = {1'b0, q.cfg[ebu_pkg::BC_WAIT_LSB +: ebu_pkg::BC_WAIT_W]};
                    if (q.cfg[ebu_pkg::BC_RWDELAY]) begin
                        n.st = ebu_pkg::S_DELAY; // R4
                    end else begin
                        n.st  = ebu_pkg::S_DATA;
                        n.rdN = q.write;
                        n.wrN = !q.write;
                    end
                end
            end
            ebu_pkg::S_DELAY: begin
                n.st  = ebu_pkg::S_DATA;
                n.rdN = q.write;
                n.wrN = !q.write;
            end
            ebu_pkg::S_DATA, ebu_pkg::S_READY: begin
                if (q.st == ebu_pkg::S_DATA && q.cnt != 5'h00) begin
                    n.cnt = q.cnt - 5'h01; // R4
                end else if (q.cfg[ebu_pkg::BC_RDYEN] && !readyActive) begin
                    n.st = ebu_pkg::S_READY; // R10
                end else begin
                    n.rdata = wideMode ? sharedDataPortIn
                                       : {8'h00, sharedDataPortIn[7:0]}; // R2
                    n.rdN   = 1'b1;
                    n.wrN   = 1'b1;
                    n.csN   = ebu_pkg::CS_IDLE;
                    n.oeLo  = 1'b0;
                    n.oeHi  = 1'b0;
                    if (q.cfg[ebu_pkg::BC_TRISTATE]) begin
                        n.st = ebu_pkg::S_FLOAT; // R4
                    end else begin
                        n.st        = ebu_pkg::S_IDLE;
                        n.respValid = 1'b1;
                    end
                end
            end
            ebu_pkg::S_FLOAT: begin
                n.st        = ebu_pkg::S_IDLE;
                n.respValid = 1'b1;
            end
            ebu_pkg::S_HOLD: begin
                // Pins floated last cycle; acknowledge until hold is released
                n.busReqN = !reqValid; // R12
                if (holdNIn || !holdEnableBit || ackPinDirectionBit) begin
                    n.holdAckN = 1'b1;
                    n.busReqN  = 1'b1;
                    n.st       = ebu_pkg::S_IDLE;
                end else begin
                    n.holdAckN = 1'b0; // R19
                end
            end
        endcase
        if (!holdEnableBit) begin
            n.busReqN  = 1'b1;
            n.holdAckN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q.st       <= ebu_pkg::S_IDLE;
            q.cnt      <= 5'h00;
            q.cfg      <= 16'h0000;
            q.addr     <= 24'h000000;
            q.wdata    <= 16'h0000;
            q.write    <= 1'b0;
            q.ale      <= 1'b0;
            q.rdN      <= 1'b1;
            q.wrN      <= 1'b1;
            q.csN      <= ebu_pkg::CS_IDLE;
            q.csNext   <= ebu_pkg::CS_IDLE;
            q.csPend   <= 1'b0;
            q.dataOut  <= 16'h0000;
            q.oeLo     <= 1'b0;
            q.oeHi     <= 1'b0;
            q.rdata    <= 16'h0000;
            q.respValid <= 1'b0;
            q.respErr  <= 1'b0;
            q.own      <= 1'b1;
            q.holdAckN <= 1'b1;
            q.busReqN  <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign respValid         = q.respValid;
    assign respErr           = q.respErr;
    assign respRdata         = q.rdata;
    assign addressPortOut    = muxMode ? 16'h0000 : q.addr[15:0]; // R2
    assign segAddrOut        = q.addr[23:16] & segMask; // R15
    assign segAddrOe         = (q.own && !singleChip) ? segMask : 8'h00;
    assign sharedDataPortOut = q.dataOut;
    assign dataPortLowOe     = q.oeLo && q.own;
    assign dataPortHighOe    = q.oeHi && q.own;
    assign aleOut            = q.ale;
    assign rdNOut            = q.rdN;
    assign wrNOut            = q.wrN;
    assign chipSelectNOut    = q.csN;
    assign busOwnOe          = q.own && !singleChip; // R19
    assign busRequestNOut    = q.busReqN;
    assign busRequestOe      = holdEnableBit; // R12
    assign holdAckNOut       = q.holdAckN;
    assign holdAckOe         = holdEnableBit && !ackPinDirectionBit; // R13
    assign busBusy           = (q.st != ebu_pkg::S_IDLE) && (q.st != ebu_pkg::S_HOLD);
endmodule

//--- ebu_mem_model.sv
// External memory model with a programmable ready delay
`timescale 1ns/1ps
module ebu_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        aleOut,
    input  wire logic        rdNOut,
    input  wire logic        wrNOut,
    input  wire logic [15:0] addressPortOut,
    input  wire logic [15:0] sharedDataPortOut,
    input  wire logic        readyPol,
    input  wire logic [3:0]  readyDelay,
    output logic      [15:0] sharedDataPortIn,
    output logic             readyIn
);
    logic [15:0] mem [256];
    logic [15:0] adr;
    logic [15:0] last;
    logic [3:0]  cnt = 4'h0;
    wire         strobe = !rdNOut || !wrNOut;

    always @(posedge sys_clk) begin
        if (aleOut) adr <= (addressPortOut != 16'h0000) ? addressPortOut : sharedDataPortOut;
        cnt <= strobe ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        if (!wrNOut) mem[adr[8:1]] <= sharedDataPortOut;
        if (!rdNOut) last <= mem[adr[8:1]];
    end
    // Outside a read the lines show a value unlike the last one
    assign sharedDataPortIn = !rdNOut ? mem[adr[8:1]] : ~last;
    assign readyIn = (strobe && cnt >= readyDelay) ? readyPol : !readyPol;
endmodule

//--- ebu_props.sv
// Concurrent checks on the external bus unit ports
`timescale 1ns/1ps
module ebu_props (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       holdEnableBit,
    input wire logic       chipSelectTimingBit,
    input wire logic       ackPinDirectionBit,
    input wire logic       aleOut,
    input wire logic [4:0] chipSelectNOut,
    input wire logic       busOwnOe,
    input wire logic       busBusy,
    input wire logic       holdNIn,
    input wire logic       holdAckNOut,
    input wire logic       holdAckOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_cs_start;
        chipSelectNOut != ebu_pkg::CS_IDLE && $past(chipSelectNOut) == ebu_pkg::CS_IDLE;
    endsequence

    property p_cs_one; $onehot0(~chipSelectNOut); endproperty
    a_cs_one: assert property (p_cs_one) else $error("two selects active");
    property p_hold_off; !holdEnableBit |-> holdAckNOut; endproperty
    a_hold_off: assert property (p_hold_off) else $error("ack without enable");
    property p_master_ack; holdEnableBit && !ackPinDirectionBit |-> holdAckOe; endproperty
    a_master_ack: assert property (p_master_ack) else $error("master ack not driven");
    property p_slave_ack; holdEnableBit && ackPinDirectionBit |-> !holdAckOe; endproperty
    a_slave_ack: assert property (p_slave_ack) else $error("slave drives ack");
    property p_cs_lag;
        (s_cs_start and !chipSelectTimingBit) |-> $past(aleOut) && !$past(aleOut, 2);
    endproperty
    a_cs_lag: assert property (p_cs_lag) else $error("select lag wrong");
    property p_cs_ale; (s_cs_start and chipSelectTimingBit) |-> $rose(aleOut); endproperty
    a_cs_ale: assert property (p_cs_ale) else $error("select not with ale");
    property p_hold_seq;
        holdEnableBit && !ackPinDirectionBit && !holdNIn && holdAckNOut && busOwnOe && !busBusy
            |=> !busOwnOe ##1 !holdAckNOut;
    endproperty
    a_hold_seq: assert property (p_hold_seq) else $error("hold sequence wrong");
    property p_ack_float; !ackPinDirectionBit && !holdAckNOut |-> !busOwnOe && !busBusy; endproperty
    a_ack_float: assert property (p_ack_float) else $error("ack while driving");

    c_hold: cover property (!holdAckNOut);
    c_cs_fast: cover property (chipSelectTimingBit && $rose(aleOut));
    c_slave: cover property (ackPinDirectionBit && busOwnOe && busBusy);
endmodule

bind ebu_external_bus_unit ebu_props u_props (.sys_clk, .rst, .holdEnableBit,
    .chipSelectTimingBit, .ackPinDirectionBit, .aleOut, .chipSelectNOut, .busOwnOe,
    .busBusy, .holdNIn, .holdAckNOut, .holdAckOe);

//--- ebu_window_decode.sv
// Bus unit constants and the address window decoder
`timescale 1ns/1ps
package ebu_pkg;
    // Window bus configuration fields
    localparam int BC_WAIT_LSB   = 0;
    localparam int BC_WAIT_W     = 4;
    localparam int BC_TRISTATE   = 4;
    localparam int BC_RWDELAY    = 5;
    localparam int BC_ALELONG    = 6;
    localparam int BC_MODE_LSB   = 7;
    localparam int BC_RDYEN      = 9;
    localparam int BC_CSEN       = 10;
    localparam int BC_READY_POLARITY_BIT     = 11;
    // Bus modes
    localparam logic [1:0] MODE_8_DEMUX  = 2'h0;
    localparam logic [1:0] MODE_8_MUX    = 2'h1;
    localparam logic [1:0] MODE_16_DEMUX = 2'h2;
    localparam logic [1:0] MODE_16_MUX   = 2'h3;
    // Window address select fields
    localparam int AS_SIZE_LSB   = 0;
    localparam int AS_SIZE_W     = 4;
    localparam int AS_START_LSB  = 4;
    localparam int AS_START_W    = 12;
    localparam int WIN_ADDR_LSB  = 12;
    localparam int NUM_WIN       = 4;
    // Address space codes
    localparam logic [1:0] SPACE_64K  = 2'h0;
    localparam logic [1:0] SPACE_256K = 2'h1;
    localparam logic [1:0] SPACE_1M   = 2'h2;
    localparam logic [1:0] SPACE_16M  = 2'h3;
    localparam logic [7:0] SEG_MASK_64K  = 8'h00;
    localparam logic [7:0] SEG_MASK_256K = 8'h03;
    localparam logic [7:0] SEG_MASK_1M   = 8'h0f;
    localparam logic [7:0] SEG_MASK_16M  = 8'hff;
    // Reset and idle values
    localparam logic [4:0] CS_IDLE     = 5'h1f;
    localparam logic [2:0] SEL_DEFAULT = 3'h0;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_DELAY, S_DATA, S_READY, S_FLOAT, S_HOLD
    } ebu_state_t;
endpackage

module ebu_window_decode (
    input  wire logic [23:0]      addr,
    input  wire logic [3:0][15:0] winAddrSel,
    output logic      [2:0]       winSel
);
    logic [3:0] hit;

    genvar w;
    generate
        for (w = 0; w < ebu_pkg::NUM_WIN; w = w + 1) begin : gWin
            logic [11:0] sizeMask;
            logic [11:0] startAddr;
            logic [3:0]  sizeCode;
            always_comb begin
                sizeCode  = winAddrSel[w][ebu_pkg::AS_SIZE_LSB +: ebu_pkg::AS_SIZE_W];
                startAddr = winAddrSel[w][ebu_pkg::AS_START_LSB +: ebu_pkg::AS_START_W];
                // Window of 4K << size; low bits of the start are ignored
                sizeMask  = 12'hfff << sizeCode;
                hit[w]    = (((addr[23:ebu_pkg::WIN_ADDR_LSB] ^ startAddr) & sizeMask)
                            == 12'h000); // R18
            end
        end
    endgenerate

    // Higher numbered window wins on overlap
    always_comb begin
        if (hit[3]) begin
            winSel = 3'h4; // R6
        end else if (hit[2]) begin
            winSel = 3'h3;
        end else if (hit[1]) begin
            winSel = 3'h2; // R6
        end else if (hit[0]) begin
            winSel = 3'h1;
        end else begin
            winSel = ebu_pkg::SEL_DEFAULT; // R7
        end
    end
endmodule

//--- tb_top.sv
// Testbench for the external bus unit
`timescale 1ns/1ps
module tb_top;
    logic             sys_clk, rst, reqValid, reqWrite, reqReady, respValid, respErr;
    logic             singleChip, holdEnableBit, chipSelectTimingBit, ackPinDirectionBit;
    logic             dataPortLowOe, dataPortHighOe, aleOut, rdNOut, wrNOut, busOwnOe;
    logic             readyIn, holdNIn, busRequestNOut, busRequestOe, holdAckNIn;
    logic             holdAckNOut, holdAckOe, busBusy, readyPol, hiSeen;
    logic [1:0]       addrSpace;
    logic [3:0]       readyDelay;
    logic [4:0]       chipSelectNOut, csSeen;
    logic [7:0]       segAddrOut, segAddrOe, segOe, segVal;
    logic [15:0]      reqWdata, respRdata, addressPortOut, sharedDataPortIn;
    logic [15:0]      sharedDataPortOut, defaultBusConfig, aleData, rdata;
    logic [23:0]      reqAddr, lat;
    logic [3:0][15:0] windowBusConfig, windowAddressSelect;
    int               errors = 0, nCompared = 0, tick = 0;

    ebu_external_bus_unit uut (.sys_clk, .rst, .reqValid, .reqWrite, .reqAddr, .reqWdata,
        .reqReady, .respValid, .respErr, .respRdata, .singleChip, .holdEnableBit,
        .chipSelectTimingBit, .ackPinDirectionBit, .addrSpace, .defaultBusConfig,
        .windowBusConfig, .windowAddressSelect, .addressPortOut, .segAddrOut, .segAddrOe,
        .sharedDataPortIn, .sharedDataPortOut, .dataPortLowOe, .dataPortHighOe, .aleOut,
        .rdNOut, .wrNOut, .chipSelectNOut, .busOwnOe, .readyIn, .holdNIn, .busRequestNOut,
        .busRequestOe, .holdAckNIn, .holdAckNOut, .holdAckOe, .busBusy);
    ebu_mem_model model (.sys_clk, .aleOut, .rdNOut, .wrNOut, .addressPortOut,
        .sharedDataPortOut, .readyPol, .readyDelay, .sharedDataPortIn, .readyIn);

    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        tick <= tick + 1;
        csSeen <= csSeen | ~chipSelectNOut;
        hiSeen <= hiSeen | dataPortHighOe;
        if (aleOut) {segOe, segVal} <= {segAddrOe, segAddrOut};
        if (aleOut && dataPortLowOe) aleData <= sharedDataPortOut;
        if (tick == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && nCompared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One request; lat is 1 when the answer stands in the cycle after the take edge
    task automatic op(input logic w, input logic [23:0] a, input logic [15:0] d);
        int k;
        @(negedge sys_clk);
        csSeen = '0;
        hiSeen = 0;
        reqValid = 1;
        reqWrite = w;
        reqAddr = a;
        reqWdata = d;
        k = 0;
        // Ready is judged between edges; the next rising edge takes the request
        while (reqReady !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        reqValid = 0;
        lat = 24'h000001;
        while (respValid !== 1'b1 && k < 400) begin
            @(negedge sys_clk);
            lat++;
            k++;
        end
        rdata = respRdata;
    endtask

    task automatic s_default();
        logic [7:0] m [4] = '{8'h00, 8'h03, 8'h0f, 8'hff};
        for (int s = 0; s < 4; s++) begin
            addrSpace = 2'(s);
            op(1, 24'hf00100 + 24'(2 * s), 16'h1230 + 16'(s));
            op(0, 24'hf00100 + 24'(2 * s), 16'h0000);
            chk(rdata, 24'h001230 + 24'(s));
            chk(lat, 24'h3);
            chk(csSeen, 24'h01);
            chk(segOe, m[s]);
            chk(segVal, {16'h0000, 8'hf0 & m[s]});
        end
        defaultBusConfig = 16'h0573;
        chipSelectTimingBit = 1;
        op(0, 24'hf00100, 16'h0000);
        chk(lat, 24'h9);
        defaultBusConfig = 16'h0500;
        chipSelectTimingBit = 0;
    endtask

    task automatic s_overlap();
        op(1, 24'h010004, 16'habcd);
        op(0, 24'h010004, 16'h0000);
        chk(rdata, 24'h0000cd);
        chk(csSeen, 24'h04);
        chk(hiSeen, 24'h0);
    endtask

    task automatic s_ready();
        logic [23:0] base;
        for (int p = 0; p < 2; p++) begin
            readyPol = p[0];
            windowBusConfig[3] = 16'h0780 | (16'(p) << 11);
            readyDelay = 4'h0;
            op(1, 24'h020008, 16'h5a5a);
            chk(aleData, 24'h000008);
            op(0, 24'h020008, 16'h0000);
            base = lat;
            chk(rdata, 24'h005a5a);
            readyDelay = 4'h5;
            op(0, 24'h020008, 16'h0000);
            chk(lat, base + 24'h5);
            chk(csSeen, 24'h10);
        end
    endtask

    task automatic s_single();
        singleChip = 1;
        op(0, 24'h000010, 16'h0000);
        chk(respErr, 24'h1);
        chk(lat, 24'h1);
        chk(csSeen, 24'h0);
        singleChip = 0;
    endtask

    task automatic s_hold();
        holdEnableBit = 1;
        @(negedge sys_clk);
        chk(holdAckOe, 24'h1);
        chk(busRequestOe, 24'h1);
        holdNIn = 0;
        repeat (3) @(negedge sys_clk);
        chk(holdAckNOut, 24'h0);
        chk(busOwnOe, 24'h0);
        reqValid = 1;
        @(negedge sys_clk);
        chk(reqReady, 24'h0);
        reqValid = 0;
        holdNIn = 1;
        repeat (3) @(negedge sys_clk);
        chk(holdAckNOut, 24'h1);
        chk(busOwnOe, 24'h1);
        op(0, 24'hf00100, 16'h0000);
        chk(rdata, 24'h001230);
        holdEnableBit = 0;
    endtask

    task automatic s_slave();
        ackPinDirectionBit = 1;
        holdEnableBit = 1;
        @(negedge sys_clk);
        chk(holdAckOe, 24'h0);
        fork
            op(0, 24'hf00100, 16'h0000);
            begin
                repeat (3) @(negedge sys_clk);
                chk(busRequestNOut, 24'h0);
                holdAckNIn = 0;
            end
        join
        chk(rdata, 24'h001230);
        holdAckNIn = 1;
    endtask

    initial begin
        {reqValid, reqWrite, singleChip, holdEnableBit} = 4'h0;
        {chipSelectTimingBit, ackPinDirectionBit, readyPol} = 3'h0;
        {holdNIn, holdAckNIn} = 2'h3;
        reqAddr = '0;
        reqWdata = '0;
        addrSpace = 2'h3;
        readyDelay = 4'h0;
        defaultBusConfig = 16'h0500;
        windowAddressSelect = {16'h0200, 16'h0200, 16'h0100, 16'h0100};
        windowBusConfig = {16'h0780, 16'h0500, 16'h0400, 16'h0500};
        rst = 1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 0;
        s_default();
        s_overlap();
        s_ready();
        s_single();
        s_hold();
        s_slave();
        test_done();
    end
endmodule
